/* File: verilog/msix_interrupt_engine.sv */
// Overview of operation
// RULE1: up to 2K vectors, shared by queues
// RULE2: eight vectors per function with VFs
// RULE3: 32 vectors per PF without SR-IOV
// RULE4: every vector owns an aggregation ring; the code keeps 256 rings, picked by the vector's low 8 bits
// RULE5: ring entry holds queue id, status
// RULE6: queue vector comes from programmable context
// RULE7: MSI-X works with and without SR-IOV
// RULE8: error events raise asynchronous interrupts too
// RULE9: error broadcast, per-PF status kept
// RULE10: four queue sources, both directions, both kinds
// RULE11: one engine serves queues and errors
// RULE12: requester gives direct flag and vector
// RULE13: direct vector indexes the MSI-X table
// RULE14: indirect vector selects the aggregation ring
// RULE15: requester takes vector from its context
// RULE16: direct request sends MSI-X at once
// RULE17: fair arbitration, one request at once
// RULE18: indirect: context, write, completion, then MSI-X
// RULE19: ring MSI-X only when waiting, then running
// RULE20: consumer update resends or clears state
// RULE21: colour flips on every ring wrap
`timescale 1ns/1ns
`default_nettype none
module msix_interrupt_engine #(
    parameter int NUM_PF = 4
) (
    input  wire logic                                          clk_sys_in,
    input  wire logic                                          rst_in,
    input  wire logic [msix_pkg::ADDR_W-1:0]                   reg_addr_in,
    input  wire logic [31:0]                                   reg_wdata_in,
    input  wire logic                                          reg_wr_in,
    input  wire logic                                          reg_rd_in,
    output logic      [31:0]                                   reg_rdata_out,
    input  wire logic [msix_pkg::NUM_SRC-1:0]                  req_valid_in,
    input  wire logic [msix_pkg::NUM_SRC-1:0]                  req_indirect_in,
    input  wire logic [msix_pkg::NUM_SRC-1:0][msix_pkg::VEC_W-1:0]  req_vector_in,
    input  wire logic [msix_pkg::NUM_SRC-1:0][msix_pkg::QID_W-1:0]  req_qid_in,
    input  wire logic [msix_pkg::NUM_SRC-1:0][msix_pkg::STAT_W-1:0] req_status_in,
    output logic      [msix_pkg::NUM_SRC-1:0]                  req_ack_out,
    output logic                                               msix_valid_out,
    output logic      [msix_pkg::VEC_W-1:0]                    msix_vector_out,
    input  wire logic                                          msix_done_in,
    output logic                                               ring_wr_valid_out,
    output logic      [63:0]                                   ring_wr_addr_out,
    output logic      [63:0]                                   ring_wr_data_out,
    input  wire logic                                          ring_wr_ready_in,
    input  wire logic                                          ring_wr_done_in
);
    import msix_pkg::*;

    function automatic logic [3:0] rr_pick(input logic [NUM_SRC-1:0] req, input logic [2:0] ptr);
        logic [3:0] res;
        int         j;
        res = 4'h0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            j = (int'(ptr) + i) % NUM_SRC;
            if (req[j]) begin
                res = {1'b1, 3'(j)};
            end
        end
        return res;
    endfunction

    eng_state_type         state_r;
    logic [2:0]            rr_ptr_r;
    logic [2:0]            cur_src_r;
    logic [RING_W-1:0]     cur_ring_r;
    logic                  sriov_en_r;
    logic [RING_W-1:0]     ring_sel_r;
    logic [NUM_PF-1:0]     err_pf_status_r;
    logic                  resend_pend_r;
    logic [VEC_W-1:0]      resend_vec_r;
    logic [31:0]           rd_nxt;

    logic [BADDR_W-1:0]    ctx_baddr_r  [NUM_RING];
    logic [2:0]            ctx_psize_r  [NUM_RING];
    logic [VEC_W-1:0]      ctx_vec_r    [NUM_RING];
    logic [FUNC_W-1:0]     ctx_func_r   [NUM_RING];
    logic [IDX_W-1:0]      ctx_pidx_r   [NUM_RING];
    logic                  ctx_color_r  [NUM_RING];
    logic                  ctx_ring_service_state_r [NUM_RING];

    // an acked source is masked for one cycle so its held request is not taken twice
    wire logic [NUM_SRC-1:0] eligible   = req_valid_in & ~req_ack_out;
    wire logic [3:0]         pick       = rr_pick(eligible, rr_ptr_r);
    wire logic               pick_found = pick[3];
    wire logic [2:0]         pick_idx   = pick[2:0];
    wire logic [VEC_W-1:0]   pick_vec   = req_vector_in[pick_idx];
    wire logic               pick_ind   = req_indirect_in[pick_idx];
    wire logic [RING_W-1:0]  pick_ring  = pick_vec[RING_W-1:0];
    wire logic               accept     = state_r == ST_IDLE && !resend_pend_r && pick_found;

    wire logic [IDX_W-1:0]   acc_pidx   = ctx_pidx_r[pick_ring];
    wire logic [63:0]        acc_addr   = {ctx_baddr_r[pick_ring], {PAGE_LSB{1'b0}}} + (64'(acc_pidx) << ENT_SHIFT);

    wire logic [IDX_W-1:0]   cur_pidx   = ctx_pidx_r[cur_ring_r];
    wire logic               cur_color  = ctx_color_r[cur_ring_r];
    wire logic               cur_ring_service_state = ctx_ring_service_state_r[cur_ring_r];
    wire logic [IDX_W-1:0]   cur_last   = {ctx_psize_r[cur_ring_r], {PAGE_IDX_W{1'b1}}};
    wire logic               cur_wrap   = cur_pidx == cur_last;
    wire logic               ring_done  = state_r == ST_RING_WAIT && ring_wr_done_in;

    wire logic               wr_ctrl    = reg_wr_in && reg_addr_in == REG_CTRL;
    wire logic               wr_sel     = reg_wr_in && reg_addr_in == REG_RING_SEL;
    wire logic               wr_blo     = reg_wr_in && reg_addr_in == REG_BASE_LO;
    wire logic               wr_bhi     = reg_wr_in && reg_addr_in == REG_BASE_HI;
    wire logic               wr_cfg     = reg_wr_in && reg_addr_in == REG_CFG;
    wire logic               wr_err     = reg_wr_in && reg_addr_in == REG_ERR_STATUS;
    wire logic               wr_cu      = reg_wr_in && reg_addr_in == REG_CONSUMER_UPDATE;
    wire logic [RING_W-1:0]  cu_ring    = reg_wdata_in[CU_RING_LSB +: RING_W];
    wire logic               cu_match   = reg_wdata_in[IDX_W-1:0] == ctx_pidx_r[cu_ring];

    // with VFs a function holds 8 vectors, otherwise a PF holds 32
    function automatic logic [VEC_W-1:0] map_vec(input logic [RING_W-1:0] r);
        return sriov_en_r ? {ctx_func_r[r], ctx_vec_r[r][VF_VEC_W-1:0]} :             // RULE2 RULE7
                            {ctx_func_r[r][VEC_W-PF_VEC_W-1:0], ctx_vec_r[r][PF_VEC_W-1:0]}; // RULE3
    endfunction

    wire logic [VEC_W-1:0]   cur_vec    = map_vec(cur_ring_r);

    logic [63:0] entry;
    always_comb begin
        entry = 64'h0;
        entry[ENT_COLOR_BIT] = ctx_color_r[pick_ring];
        entry[ENT_SRC_LSB +: 3] = pick_idx;
        entry[ENT_QID_LSB +: QID_W] = req_qid_in[pick_idx];       // RULE5
        entry[ENT_STAT_LSB +: STAT_W] = req_status_in[pick_idx];  // RULE5
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            state_r           <= ST_IDLE;
            rr_ptr_r          <= 3'h0;
            cur_src_r         <= 3'h0;
            cur_ring_r        <= '0;
            req_ack_out       <= '0;
            msix_valid_out    <= 1'b0;
            msix_vector_out   <= '0;
            ring_wr_valid_out <= 1'b0;
            ring_wr_addr_out  <= 64'h0;
            ring_wr_data_out  <= 64'h0;
        end else begin
            req_ack_out <= '0;
            case (state_r)
                ST_IDLE: begin
                    if (resend_pend_r) begin
                        state_r         <= ST_MSIX;  // RULE20
                        msix_valid_out  <= 1'b1;
                        msix_vector_out <= resend_vec_r;
                    end else if (pick_found) begin
                        req_ack_out[pick_idx] <= 1'b1;  // RULE17
                        rr_ptr_r  <= (pick_idx == 3'(NUM_SRC - 1)) ? 3'h0 : pick_idx + 3'h1;  // RULE17
                        cur_src_r <= pick_idx;          // RULE10 RULE11
                        if (pick_ind) begin
                            cur_ring_r        <= pick_ring;  // RULE14 RULE4
                            state_r           <= ST_RING_WR; // RULE18
                            ring_wr_valid_out <= 1'b1;
                            ring_wr_addr_out  <= acc_addr;
                            ring_wr_data_out  <= entry;
                        end else begin
                            state_r         <= ST_MSIX;     // RULE16
                            msix_valid_out  <= 1'b1;
                            msix_vector_out <= pick_vec;    // RULE13 RULE6 RULE1
                        end
                    end
                end
                ST_MSIX: begin
                    if (msix_done_in) begin
                        state_r        <= ST_IDLE;
                        msix_valid_out <= 1'b0;
                    end
                end
                ST_RING_WR: begin
                    if (ring_wr_ready_in) begin
                        state_r           <= ST_RING_WAIT;
                        ring_wr_valid_out <= 1'b0;
                    end
                end
                ST_RING_WAIT: begin
                    // the message goes out only once the entry is known to be in host memory
                    if (ring_wr_done_in) begin
                        if (cur_ring_service_state == RING_SERVICE_STATE_WAIT) begin
                            state_r         <= ST_MSIX;  // RULE18 RULE19
                            msix_valid_out  <= 1'b1;
                            msix_vector_out <= cur_vec;
                        end else begin
                            state_r <= ST_IDLE;          // RULE19
                        end
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            sriov_en_r      <= SRIOV_RST;
            ring_sel_r      <= '0;
            err_pf_status_r <= '0;
            resend_pend_r   <= 1'b0;
            resend_vec_r    <= '0;
            reg_rdata_out   <= 32'h0;
        end else begin
            reg_rdata_out <= reg_rd_in ? rd_nxt : 32'h0;
            if (wr_ctrl) begin
                sriov_en_r <= reg_wdata_in[0];  // RULE7
            end
            if (wr_sel) begin
                ring_sel_r <= reg_wdata_in[RING_W-1:0];
            end
            if (wr_err) begin
                err_pf_status_r <= err_pf_status_r & ~reg_wdata_in[NUM_PF-1:0];
            end
            if (accept && pick_idx == SRC_ERR) begin
                err_pf_status_r <= '1;  // RULE8 RULE9
            end
            if (state_r == ST_IDLE && resend_pend_r) begin
                resend_pend_r <= 1'b0;
            end
            // a single pending resend; a second update before it goes out only refreshes the vector
            if (wr_cu && !cu_match) begin
                resend_pend_r <= 1'b1;  // RULE20
                resend_vec_r  <= map_vec(cu_ring);
            end
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < NUM_RING; i++) begin
                ctx_pidx_r[i]   <= '0;
                ctx_color_r[i]  <= COLOR_RST;
                ctx_ring_service_state_r[i] <= RING_SERVICE_STATE_WAIT;
            end
        end else begin
            if (wr_cfg) begin
                ctx_pidx_r[ring_sel_r]   <= '0;
                ctx_color_r[ring_sel_r]  <= reg_wdata_in[CFG_COLOR_BIT];
                ctx_ring_service_state_r[ring_sel_r] <= RING_SERVICE_STATE_WAIT;
            end
            if (ring_done) begin
                ctx_pidx_r[cur_ring_r] <= cur_wrap ? '0 : cur_pidx + IDX_W'(1);
                if (cur_wrap) begin
                    ctx_color_r[cur_ring_r] <= ~cur_color;  // RULE21
                end
            end
            if (wr_cu && cu_match) begin
                ctx_ring_service_state_r[cu_ring] <= RING_SERVICE_STATE_WAIT;  // RULE20
            end
            // setting after the clear lets a fresh trigger win over a software clear
            if (ring_done && cur_ring_service_state == RING_SERVICE_STATE_WAIT) begin
                ctx_ring_service_state_r[cur_ring_r] <= RING_SERVICE_STATE_RUN;  // RULE19
            end
        end
    end

    // software-owned context fields need no reset
    always_ff @(posedge clk_sys_in) begin
        if (wr_blo) begin
            ctx_baddr_r[ring_sel_r][BADDR_LO_W-1:0] <= reg_wdata_in[31:PAGE_LSB];
        end
        if (wr_bhi) begin
            ctx_baddr_r[ring_sel_r][BADDR_W-1:BADDR_LO_W] <= reg_wdata_in;
        end
        if (wr_cfg) begin
            ctx_psize_r[ring_sel_r] <= reg_wdata_in[CFG_PSIZE_LSB +: 3];
            ctx_vec_r[ring_sel_r]   <= reg_wdata_in[CFG_VEC_LSB +: VEC_W];  // RULE6
            ctx_func_r[ring_sel_r]  <= reg_wdata_in[CFG_FUNC_LSB +: FUNC_W];
        end
    end

    always_comb begin
        rd_nxt = 32'h0;
        case (reg_addr_in)
            REG_CTRL:       rd_nxt[0] = sriov_en_r;
            REG_RING_SEL:   rd_nxt[RING_W-1:0] = ring_sel_r;
            REG_BASE_LO:    rd_nxt[31:PAGE_LSB] = ctx_baddr_r[ring_sel_r][BADDR_LO_W-1:0];
            REG_BASE_HI:    rd_nxt = ctx_baddr_r[ring_sel_r][BADDR_W-1:BADDR_LO_W];
            REG_CFG: begin
                rd_nxt[CFG_PSIZE_LSB +: 3]      = ctx_psize_r[ring_sel_r];
                rd_nxt[CFG_VEC_LSB +: VEC_W]    = ctx_vec_r[ring_sel_r];
                rd_nxt[CFG_FUNC_LSB +: FUNC_W]  = ctx_func_r[ring_sel_r];
                rd_nxt[CFG_COLOR_BIT]           = ctx_color_r[ring_sel_r];
            end
            REG_STATUS: begin
                rd_nxt[IDX_W-1:0]     = ctx_pidx_r[ring_sel_r];
                rd_nxt[STS_COLOR_BIT] = ctx_color_r[ring_sel_r];
                rd_nxt[STS_RING_SERVICE_STATE_BIT] = ctx_ring_service_state_r[ring_sel_r];
            end
            REG_ERR_STATUS: rd_nxt[NUM_PF-1:0] = err_pf_status_r;
            default:        rd_nxt = 32'h0;
        endcase
    end

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    sequence s_accept;
        accept;
    endsequence
    sequence s_ring_done;
        ring_done;
    endsequence

    ack_one_hot_a: assert property (s_accept |=> req_ack_out[$past(pick_idx)] && $onehot(req_ack_out)) // RULE17
        else $error("accepted source not acked alone");
    direct_msix_vec_a: assert property (s_accept ##0 !pick_ind |=> msix_valid_out && !ring_wr_valid_out // RULE16
        && msix_vector_out == $past(pick_vec))
        else $error("direct request did not send its vector");
    indirect_ring_a: assert property (s_accept ##0 pick_ind |=> ring_wr_valid_out && !msix_valid_out // RULE14
        && cur_ring_r == $past(pick_ring) && ring_wr_addr_out == $past(acc_addr))
        else $error("indirect request did not write its ring");
    msix_after_write_a: assert property (state_r inside {ST_RING_WR, ST_RING_WAIT} |-> !msix_valid_out) // RULE18
        else $error("message sent before ring write completed");
    ring_gate_run_a: assert property (s_ring_done ##0 cur_ring_service_state == RING_SERVICE_STATE_WAIT |=> msix_valid_out // RULE19
        && ctx_ring_service_state_r[cur_ring_r] == RING_SERVICE_STATE_RUN && msix_vector_out == $past(cur_vec))
        else $error("waiting ring not signalled or not marked running");
    ring_gate_hold_a: assert property (s_ring_done ##0 cur_ring_service_state == RING_SERVICE_STATE_RUN |=> state_r == ST_IDLE // RULE19
        && !msix_valid_out)
        else $error("running ring signalled again");
    cidx_clear_a: assert property (wr_cu && cu_match && !ring_done |=> ctx_ring_service_state_r[$past(cu_ring)] == RING_SERVICE_STATE_WAIT) // RULE20
        else $error("matching consumer update did not clear state");
    cidx_resend_a: assert property (wr_cu && !cu_match |=> resend_pend_r ##1 msix_valid_out[*1] or resend_pend_r[*2]) // RULE20
        else $error("mismatching consumer update lost its resend");
    colour_wrap_a: assert property (s_ring_done ##0 cur_wrap |=> ctx_pidx_r[cur_ring_r] == '0 // RULE21
        && ctx_color_r[cur_ring_r] != $past(cur_color))
        else $error("colour not flipped on wrap");
    err_broadcast_a: assert property (s_accept ##0 pick_idx == SRC_ERR |=> &err_pf_status_r) // RULE9
        else $error("error not broadcast to every PF");
endmodule
`default_nettype wire

/* File: pkg/msix_pkg.sv */
package msix_pkg;
    localparam int NUM_SRC   = 5;
    localparam int VEC_W     = 11;
    localparam int FUNC_W    = 8;
    localparam int RING_W    = 8;
    localparam int NUM_RING  = 256;
    localparam int IDX_W     = 12;
    localparam int QID_W     = 12;
    localparam int STAT_W    = 16;
    localparam int ADDR_W    = 18;
    localparam int BADDR_W   = 52;
    localparam int BADDR_LO_W = 20;
    localparam int PAGE_LSB  = 12;
    localparam int VF_VEC_W  = 3;
    localparam int PF_VEC_W  = 5;
    localparam int ENT_SHIFT = 3;
    localparam int PAGE_IDX_W = 9;

    localparam logic [2:0] SRC_H2C_MM = 3'h0;
    localparam logic [2:0] SRC_H2C_ST = 3'h1;
    localparam logic [2:0] SRC_C2H_MM = 3'h2;
    localparam logic [2:0] SRC_C2H_ST = 3'h3;
    localparam logic [2:0] SRC_ERR    = 3'h4;

    localparam logic [ADDR_W-1:0] REG_CTRL            = 18'h00000;
    localparam logic [ADDR_W-1:0] REG_RING_SEL        = 18'h00004;
    localparam logic [ADDR_W-1:0] REG_BASE_LO         = 18'h00008;
    localparam logic [ADDR_W-1:0] REG_BASE_HI         = 18'h0000C;
    localparam logic [ADDR_W-1:0] REG_CFG             = 18'h00010;
    localparam logic [ADDR_W-1:0] REG_STATUS          = 18'h00014;
    localparam logic [ADDR_W-1:0] REG_ERR_STATUS      = 18'h00018;
    localparam logic [ADDR_W-1:0] REG_CONSUMER_UPDATE = 18'h18000;

    localparam int CFG_PSIZE_LSB  = 0;
    localparam int CFG_VEC_LSB    = 4;
    localparam int CFG_FUNC_LSB   = 16;
    localparam int CFG_COLOR_BIT  = 24;
    localparam int STS_COLOR_BIT  = 16;
    localparam int STS_RING_SERVICE_STATE_BIT = 17;
    localparam int CU_RING_LSB    = 16;
    localparam int ENT_STAT_LSB   = 0;
    localparam int ENT_QID_LSB    = 16;
    localparam int ENT_SRC_LSB    = 60;
    localparam int ENT_COLOR_BIT  = 63;

    localparam logic COLOR_RST   = 1'b1;
    localparam logic SRIOV_RST   = 1'b0;
    localparam logic RING_SERVICE_STATE_WAIT = 1'b0;
    localparam logic RING_SERVICE_STATE_RUN  = 1'b1;

    typedef enum logic [1:0] {
        ST_IDLE      = 2'b00,
        ST_MSIX      = 2'b01,
        ST_RING_WR   = 2'b10,
        ST_RING_WAIT = 2'b11
    } eng_state_type;
endpackage

/* File: testbench/msix_pcie_model.sv */
`timescale 1ns/1ns
`default_nettype none
module msix_pcie_model (
    input  wire logic       clk_sys_in,
    input  wire logic       rst_in,
    input  wire logic [3:0] delay_in,
    input  wire logic       msix_valid_in,
    input  wire logic       ring_wr_valid_in,
    output logic            msix_done_out,
    output logic            ring_wr_ready_out,
    output logic            ring_wr_done_out
);
    logic [3:0] msix_cnt_r;
    logic [3:0] wr_cnt_r;
    logic [3:0] cpl_cnt_r;
    logic       cpl_pend_r;

    // every answer is a one-cycle pulse after delay_in idle cycles, so a slow host is one setting away
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            msix_done_out <= 1'b0;
            ring_wr_ready_out <= 1'b0;
            ring_wr_done_out <= 1'b0;
            msix_cnt_r <= 4'h0;
            wr_cnt_r <= 4'h0;
            cpl_cnt_r <= 4'h0;
            cpl_pend_r <= 1'b0;
        end else begin
            msix_done_out <= 1'b0;
            ring_wr_ready_out <= 1'b0;
            ring_wr_done_out <= 1'b0;
            if (msix_valid_in && !msix_done_out) begin
                msix_cnt_r <= (msix_cnt_r >= delay_in) ? 4'h0 : msix_cnt_r + 4'h1;
                msix_done_out <= (msix_cnt_r >= delay_in);
            end
            if (ring_wr_valid_in && !ring_wr_ready_out) begin
                wr_cnt_r <= (wr_cnt_r >= delay_in) ? 4'h0 : wr_cnt_r + 4'h1;
                ring_wr_ready_out <= (wr_cnt_r >= delay_in);
            end
            // completion only ever follows an accepted write, never overlaps it
            if (ring_wr_ready_out) begin
                cpl_pend_r <= 1'b1;
                cpl_cnt_r <= 4'h0;
            end else if (cpl_pend_r) begin
                cpl_cnt_r <= cpl_cnt_r + 4'h1;
                ring_wr_done_out <= (cpl_cnt_r >= delay_in);
                cpl_pend_r <= (cpl_cnt_r < delay_in);
            end
        end
    end
endmodule
`default_nettype wire

/* File: testbench/msix_interrupt_engine_test.sv */
`timescale 1ns/1ns
`default_nettype none
module msix_interrupt_engine_test;
    import msix_pkg::*;
    localparam int NUM_PF = 4;
    logic                           clk_sys_in = 1'b0;
    logic                           rst_in = 1'b1;
    logic [ADDR_W-1:0]              reg_addr_in = '0;
    logic [31:0]                    reg_wdata_in = '0;
    logic                           reg_wr_in = 1'b0;
    logic                           reg_rd_in = 1'b0;
    logic [31:0]                    reg_rdata_out;
    logic [NUM_SRC-1:0]             req_valid_in = '0;
    logic [NUM_SRC-1:0]             req_indirect_in = '0;
    logic [NUM_SRC-1:0][VEC_W-1:0]  req_vector_in = '0;
    logic [NUM_SRC-1:0][QID_W-1:0]  req_qid_in = '0;
    logic [NUM_SRC-1:0][STAT_W-1:0] req_status_in = '0;
    logic [NUM_SRC-1:0]             req_ack_out;
    logic                           msix_valid_out;
    logic [VEC_W-1:0]               msix_vector_out;
    logic                           msix_done_in;
    logic                           ring_wr_valid_out;
    logic [63:0]                    ring_wr_addr_out;
    logic [63:0]                    ring_wr_data_out;
    logic                           ring_wr_ready_in;
    logic                           ring_wr_done_in;
    logic [3:0]                     delay_r = 4'h0;
    logic [63:0]                    last_vec;
    logic [63:0]                    last_addr;
    logic [63:0]                    last_data;
    int                             fail_count = 0;
    int                             n_compared = 0;
    int                             n_msix = 0;
    int                             n_ring = 0;

    always #10 clk_sys_in = ~clk_sys_in;

    msix_interrupt_engine #(.NUM_PF(NUM_PF)) dut (.clk_sys_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
        .reg_rd_in, .reg_rdata_out, .req_valid_in, .req_indirect_in, .req_vector_in, .req_qid_in, .req_status_in,
        .req_ack_out, .msix_valid_out, .msix_vector_out, .msix_done_in, .ring_wr_valid_out, .ring_wr_addr_out,
        .ring_wr_data_out, .ring_wr_ready_in, .ring_wr_done_in);

    msix_pcie_model model (.clk_sys_in, .rst_in, .delay_in(delay_r), .msix_valid_in(msix_valid_out),
        .ring_wr_valid_in(ring_wr_valid_out), .msix_done_out(msix_done_in), .ring_wr_ready_out(ring_wr_ready_in),
        .ring_wr_done_out(ring_wr_done_in));

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        if (fail_count == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    always @(posedge clk_sys_in) begin
        if (msix_valid_out === 1'b1 && msix_done_in === 1'b1) begin
            n_msix <= n_msix + 1;
            last_vec <= 64'(msix_vector_out);
        end
        if (ring_wr_valid_out === 1'b1 && ring_wr_ready_in === 1'b1) begin
            n_ring <= n_ring + 1;
            last_addr <= ring_wr_addr_out;
            last_data <= ring_wr_data_out;
        end
        if (!rst_in && req_ack_out !== '0) check(64'($onehot(req_ack_out)), 64'h1);
    end

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
        @(posedge clk_sys_in);
    endtask

    // the data word stands only in the cycle after the strobe, so it is taken at the edge ending that cycle
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        @(posedge clk_sys_in);
        check(64'(reg_rdata_out), 64'(exp));
    endtask

    task automatic req(input int s, input logic ind, input logic [VEC_W-1:0] v, input logic [QID_W-1:0] q,
                       input logic [STAT_W-1:0] st);
        int i;
        req_indirect_in[s] <= ind;
        req_vector_in[s] <= v;
        req_qid_in[s] <= q;
        req_status_in[s] <= st;
        req_valid_in[s] <= 1'b1;
        for (i = 0; i < 300 && req_ack_out[s] !== 1'b1; i++) @(posedge clk_sys_in);
        req_valid_in[s] <= 1'b0;
        if (i == 300) begin
            fail_count++;
            give_verdict;
        end
    endtask

    task automatic wait_msg(input int nm, input int nr);
        int i;
        for (i = 0; i < 300 && (n_msix < nm || n_ring < nr); i++) @(posedge clk_sys_in);
        if (i == 300) begin
            fail_count++;
            give_verdict;
        end
    endtask

    function automatic logic [63:0] ent(input logic c, input logic [2:0] s, input logic [11:0] q,
                                        input logic [15:0] st);
        return {c, s, 32'h0, q, st};
    endfunction

    initial begin
        int k;
        repeat (10) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        @(posedge clk_sys_in);
        check(64'({msix_valid_out, ring_wr_valid_out, req_ack_out}), 64'h0);
        rd(REG_STATUS, 32'h0001_0000);
        rd(REG_ERR_STATUS, 32'h0);
        rd(18'h00100, 32'h0);
        for (k = 0; k < 4; k++) begin
            req(k, 1'b0, VEC_W'(11'h7FC + k), '0, '0);
            wait_msg(k + 1, 0);
            check(last_vec, 64'(11'h7FC + k));
        end
        check(64'(n_ring), 64'h0);
        wr(REG_RING_SEL, 32'h5);
        wr(REG_BASE_LO, 32'h1234_5000);
        wr(REG_BASE_HI, 32'h0000_0001);
        wr(REG_CFG, 32'h0102_0030);
        delay_r <= 4'h3;
        req(2, 1'b1, 11'h005, 12'h0AB, 16'hBEEF);
        wait_msg(5, 1);
        check(last_addr, 64'h1_1234_5000);
        check(last_data, ent(1'b1, 3'd2, 12'h0AB, 16'hBEEF));
        check(last_vec, 64'h43);
        rd(REG_STATUS, 32'h0003_0001);
        req(3, 1'b1, 11'h005, 12'hFFF, 16'h0001);
        wait_msg(5, 2);
        repeat (12) @(posedge clk_sys_in);
        check(64'(n_msix), 64'd5);
        check(last_addr, 64'h1_1234_5008);
        wr(REG_CONSUMER_UPDATE, 32'h0005_0001);
        wait_msg(6, 2);
        check(last_vec, 64'h43);
        wr(REG_CONSUMER_UPDATE, 32'h0005_0002);
        rd(REG_STATUS, 32'h0001_0002);
        delay_r <= 4'h0;
        // fill the 512-entry ring to the wrap point; the first entry sends the message, the rest stay silent
        for (k = 0; k < 510; k++) begin
            req(k % 4, 1'b1, 11'h005, 12'(k), 16'(k));
            wait_msg(7, k + 3);
        end
        // the wrap lands with the completion, a few cycles after the write was counted
        repeat (4) @(posedge clk_sys_in);
        rd(REG_STATUS, 32'h0002_0000);
        req(0, 1'b1, 11'h005, 12'h001, 16'h0002);
        wait_msg(7, 513);
        check(last_addr, 64'h1_1234_5000);
        check(last_data, ent(1'b0, 3'd0, 12'h001, 16'h0002));
        check(64'(n_msix), 64'd7);
        wr(REG_CTRL, 32'h1);
        wr(REG_CONSUMER_UPDATE, 32'h0005_0000);
        wait_msg(8, 513);
        check(last_vec, 64'h13);
        req(4, 1'b0, 11'h02A, '0, '0);
        wait_msg(9, 513);
        check(last_vec, 64'h2A);
        rd(REG_ERR_STATUS, 32'hF);
        wr(REG_ERR_STATUS, 32'h1);
        rd(REG_ERR_STATUS, 32'hE);
        fork
            req(0, 1'b0, 11'h011, '0, '0);
            req(1, 1'b0, 11'h012, '0, '0);
        join
        wait_msg(11, 513);
        check(last_vec, 64'h12);
        check(64'(n_msix), 64'd11);
        give_verdict;
    end
endmodule
`default_nettype wire
